// ===== core/dcc_pkg.sv
/*
 * Shared constants and types of the dual comparator control block: register
 * offsets, field positions, reset values, mode codes, routing structs and the
 * settling time.
 * Assumes a single 250 MHz core clock and an 8-bit register port.
 */
`default_nettype none

package dcc_pkg;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    localparam int unsigned DCC_ADDR_W = 8;
    localparam int unsigned DCC_DATA_W = 8;

    localparam logic [7:0] DCC_CFG_ADDR = 8'h1f;
    localparam logic [7:0] DCC_IRQ_STS_ADDR = 8'h20;
    localparam logic [7:0] DCC_IRQ_MASK_ADDR = 8'h21;
    localparam logic [7:0] DCC_PORT_DIR_ADDR = 8'h22;
    localparam logic [7:0] DCC_PORT_DATA_ADDR = 8'h23;
    localparam logic [7:0] DCC_STATE_ADDR = 8'h24;

    // ------------------------------------------------------------------
    // configuration register fields
    // ------------------------------------------------------------------
    localparam int unsigned DCC_CFG_MODE_LSB = 0;
    localparam int unsigned DCC_CFG_SWITCH_BIT = 3;
    localparam int unsigned DCC_CFG_INV1_BIT = 4;
    localparam int unsigned DCC_CFG_INV2_BIT = 5;
    localparam int unsigned DCC_CFG_RES1_BIT = 6;
    localparam int unsigned DCC_CFG_RES2_BIT = 7;

    // ------------------------------------------------------------------
    // interrupt bits and reset values
    // ------------------------------------------------------------------
    localparam int unsigned DCC_IRQ_CHANGE_BIT = 0;
    localparam int unsigned DCC_IRQ_SETTLED_BIT = 1;

    localparam logic [5:0] DCC_CFG_RST = 6'h00;
    localparam logic [1:0] DCC_IRQ_RST = 2'h0;
    localparam logic [4:0] DCC_DIR_RST = 5'h1f;
    localparam logic [4:0] DCC_DATA_RST = 5'h00;
    localparam logic [7:0] DCC_RDATA_RST = 8'h00;

    // ------------------------------------------------------------------
    // modes, pins and routing
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        DCC_MODE_RESET = 3'h0,
        DCC_MODE_THREE_IN = 3'h1,
        DCC_MODE_VREF = 3'h2,
        DCC_MODE_COMMON_REF = 3'h3,
        DCC_MODE_INDEPENDENT = 3'h4,
        DCC_MODE_SINGLE = 3'h5,
        DCC_MODE_OUTPUTS = 3'h6,
        DCC_MODE_OFF = 3'h7
    } dcc_mode_t;

    localparam logic [1:0] DCC_PIN_A0 = 2'h0;
    localparam logic [1:0] DCC_PIN_A1 = 2'h1;
    localparam logic [1:0] DCC_PIN_A2 = 2'h2;
    localparam logic [1:0] DCC_PIN_A3 = 2'h3;

    typedef struct packed {
        logic enable;
        logic [1:0] inverting_pin;
        logic noninverting_vref;
        logic [1:0] noninverting_pin;
    } dcc_route_t;

    typedef struct packed {
        dcc_route_t second;
        dcc_route_t first;
        logic outputs_to_pins;
        logic [4:0] analog_pins;
    } dcc_mode_cfg_t;

    localparam dcc_route_t DCC_ROUTE_OFF = '0;

    // ------------------------------------------------------------------
    // settling after a mode or input change
    // ------------------------------------------------------------------
    localparam int unsigned DCC_SETTLE_NS = 10000;
    localparam int unsigned DCC_CLK_MHZ = 250;
    localparam int unsigned DCC_SETTLE_CYCLES = (DCC_SETTLE_NS * DCC_CLK_MHZ + 999) / 1000;
    localparam int unsigned DCC_SETTLE_W = 12;
    localparam logic [11:0] DCC_SETTLE_LAST = 12'(DCC_SETTLE_CYCLES - 1);

    typedef enum logic [1:0] {
        DCC_ST_IDLE = 2'b01,
        DCC_ST_SETTLING = 2'b10
    } dcc_settle_state_t;

endpackage

`default_nettype wire

// ===== core/dcc_channel.sv
/*
 * One comparator channel: synchronises the raw analog comparator decision and
 * applies the per-channel inversion.
 * Assumes raw_i comes straight from an analog comparator, unrelated to the clock.
 */
`default_nettype none

module dcc_channel (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // analog side
    input wire logic raw_i,
    // control
    input wire logic enable_i,
    input wire logic invert_i,
    // result
    output logic result_o
);
    import dcc_pkg::*;

    logic meta_reg;
    logic sync_reg;

    // ------------------------------------------------------------------
    // two-flop synchroniser
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            meta_reg <= 1'b0;
            sync_reg <= 1'b0;
        end else begin
            meta_reg <= raw_i;
            sync_reg <= meta_reg;
        end
    end

    // ------------------------------------------------------------------
    // inversion; a powered-down channel reads low
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            result_o <= 1'b0;
        end else begin
            result_o <= enable_i & (sync_reg ^ invert_i);
        end
    end

endmodule

`default_nettype wire

// ===== core/dcc_settle.sv
/*
 * Settling timer: after a mode or input change the comparator results are
 * held invalid for a fixed time, then a one-cycle done pulse is given.
 * Assumes start_i is a one-cycle pulse on the core clock.
 */
`default_nettype none

module dcc_settle (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // control
    input wire logic start_i,
    // status
    output logic settling_o,
    output logic done_o
);
    import dcc_pkg::*;

    dcc_settle_state_t state_reg;
    logic [DCC_SETTLE_W-1:0] count_reg;

    // ------------------------------------------------------------------
    // a new start restarts the count
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            state_reg <= DCC_ST_IDLE;
            count_reg <= '0;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            case (state_reg)
                DCC_ST_IDLE: begin
                    if (start_i) begin
                        state_reg <= DCC_ST_SETTLING;
                        count_reg <= '0;
                    end
                end
                DCC_ST_SETTLING: begin
                    if (start_i) begin
                        count_reg <= '0;
                    end else if (count_reg == DCC_SETTLE_LAST) begin
                        state_reg <= DCC_ST_IDLE;
                        done_o <= 1'b1;
                    end else begin
                        count_reg <= count_reg + 12'h001;
                    end
                end
                default: begin
                    state_reg <= DCC_ST_IDLE;
                end
            endcase
        end
    end

    assign settling_o = (state_reg == DCC_ST_SETTLING);

endmodule

`default_nettype wire

// ===== core/dcc_top.sv
/*
 * Dual comparator control: configuration register, mode decode to the analog
 * input and output multiplexers, result inversion, change detection, port A
 * direction and data, and the interrupt status, mask and line.
 * Assumes two analog comparators and a voltage reference outside, steered by
 * the route outputs, and port A pads resolved by the surroundings from the
 * out and enable signals.
 */
// Notes on behaviour
// - two independent comparators, each one result from its own input pair
// - comparator inputs share pins a0 to a3, mapped by the chosen mode
// - the on-chip voltage reference can feed the comparators
// - the configuration register steers both input and output multiplexers
// - eight modes picked by the three-bit mode field
// - the port direction register keeps deciding pin direction in every mode
// - results are flagged invalid for a settling time after a mode change
// - each result may be inverted before status bits and pins
// - configuration register at 0x1f, eight bits, reset all zero
// - mode 011: a0,a1 inverting, a2 non-inverting both; a3,a4 digital I/O
// - uninverted result is 1 when non-inverting input is higher
// - change flag sets while any result differs from the latched value
// - reading the configuration register latches results, ending the mismatch
// - reset loads the register to zero, mode 000, all comparator pins analog
`default_nettype none

module dcc_top (
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    // analog comparators and reference
    input wire logic [1:0] cmp_raw_i,
    output var dcc_pkg::dcc_route_t first_route_o,
    output var dcc_pkg::dcc_route_t second_route_o,
    // port A pins a0 to a4
    input wire logic [4:0] pin_a_in_i,
    output logic [4:0] pin_a_out_o,
    output logic [4:0] pin_a_oe_o,
    output logic [4:0] pin_a_analog_o,
    // status
    output logic result_valid_o,
    output logic irq_o
);
    import dcc_pkg::*;

    // ------------------------------------------------------------------
    // mode decode
    // ------------------------------------------------------------------
    function automatic dcc_mode_cfg_t dcc_decode(input logic [2:0] mode, input logic sw);
        dcc_mode_cfg_t c;
        c = '0;
        case (mode)
            DCC_MODE_RESET: begin
                c.analog_pins = 5'h0f;
            end
            DCC_MODE_THREE_IN: begin
                c.first = '{1'b1, (sw ? DCC_PIN_A3 : DCC_PIN_A0), 1'b0, DCC_PIN_A2};
                c.second = '{1'b1, DCC_PIN_A1, 1'b0, DCC_PIN_A2};
                c.outputs_to_pins = 1'b1;
                c.analog_pins = 5'h0f;
            end
            DCC_MODE_VREF: begin
                c.first = '{1'b1, (sw ? DCC_PIN_A3 : DCC_PIN_A0), 1'b1, DCC_PIN_A2};
                c.second = '{1'b1, (sw ? DCC_PIN_A2 : DCC_PIN_A1), 1'b1, DCC_PIN_A2};
                c.analog_pins = 5'h0f;
            end
            DCC_MODE_COMMON_REF: begin
                c.first = '{1'b1, DCC_PIN_A0, 1'b0, DCC_PIN_A2};
                c.second = '{1'b1, DCC_PIN_A1, 1'b0, DCC_PIN_A2};
                c.analog_pins = 5'h07;
            end
            DCC_MODE_INDEPENDENT: begin
                c.first = '{1'b1, DCC_PIN_A0, 1'b0, DCC_PIN_A3};
                c.second = '{1'b1, DCC_PIN_A1, 1'b0, DCC_PIN_A2};
                c.analog_pins = 5'h0f;
            end
            DCC_MODE_SINGLE: begin
                c.second = '{1'b1, DCC_PIN_A1, 1'b0, DCC_PIN_A2};
                c.analog_pins = 5'h06;
            end
            DCC_MODE_OUTPUTS: begin
                c.first = '{1'b1, DCC_PIN_A0, 1'b0, DCC_PIN_A2};
                c.second = '{1'b1, DCC_PIN_A1, 1'b0, DCC_PIN_A2};
                c.outputs_to_pins = 1'b1;
                c.analog_pins = 5'h07;
            end
            default: begin
                c.first = DCC_ROUTE_OFF; // off: all pins digital, least current
            end
        endcase
        return c;
    endfunction

    // ------------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------------
    logic [5:0] cfg_reg;
    logic [1:0] latched_reg;
    logic [1:0] irq_sts_reg;
    logic [1:0] irq_sts_next;
    logic [1:0] irq_mask_reg;
    logic [4:0] dir_reg;
    logic [4:0] data_reg;
    logic [4:0] pin_meta_reg;
    logic [4:0] pin_sync_reg;
    logic [7:0] rdata_next;
    dcc_mode_cfg_t dec;
    logic [1:0] ch_en;
    logic [1:0] ch_inv;
    logic [1:0] ch_res;
    logic cfg_wr;
    logic cfg_rd;
    logic mode_change;
    logic mismatch;
    logic settling;
    logic settle_done;

    assign cfg_wr = reg_wr_i & (reg_addr_i == DCC_CFG_ADDR);
    assign cfg_rd = reg_rd_i & (reg_addr_i == DCC_CFG_ADDR);

    // ------------------------------------------------------------------
    // configuration register
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            cfg_reg <= DCC_CFG_RST;
        end else if (cfg_wr) begin
            cfg_reg <= reg_wdata_i[5:0];
        end
    end

    // a change of input switch also re-routes inputs, so it restarts settling
    assign mode_change = cfg_wr &
        (reg_wdata_i[DCC_CFG_SWITCH_BIT:DCC_CFG_MODE_LSB] !=
         cfg_reg[DCC_CFG_SWITCH_BIT:DCC_CFG_MODE_LSB]);

    assign dec = dcc_decode(cfg_reg[DCC_CFG_MODE_LSB +: 3], cfg_reg[DCC_CFG_SWITCH_BIT]);

    // ------------------------------------------------------------------
    // comparator channels
    // ------------------------------------------------------------------
    assign ch_en = {dec.second.enable, dec.first.enable};
    assign ch_inv = {cfg_reg[DCC_CFG_INV2_BIT], cfg_reg[DCC_CFG_INV1_BIT]};

    generate
        for (genvar i = 0; i < 2; i++) begin : g_ch
            dcc_channel u_ch (
                .sys_clk_i(sys_clk_i),
                .rst_b_i(rst_b_i),
                .raw_i(cmp_raw_i[i]),
                .enable_i(ch_en[i]),
                .invert_i(ch_inv[i]),
                .result_o(ch_res[i])
            );
        end
    endgenerate

    dcc_settle u_settle (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_b_i),
        .start_i(mode_change),
        .settling_o(settling),
        .done_o(settle_done)
    );

    // ------------------------------------------------------------------
    // analog routing outputs
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            first_route_o <= DCC_ROUTE_OFF;
            second_route_o <= DCC_ROUTE_OFF;
            pin_a_analog_o <= 5'h0f;
        end else begin
            first_route_o <= dec.first;
            second_route_o <= dec.second;
            pin_a_analog_o <= dec.analog_pins;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            result_valid_o <= 1'b0;
        end else begin
            result_valid_o <= ~settling & ~mode_change & (|ch_en);
        end
    end

    // ------------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------------
    // a write also latches, as either access ends the mismatch
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            latched_reg <= 2'h0;
        end else if (cfg_rd | cfg_wr) begin
            latched_reg <= ch_res;
        end
    end

    assign mismatch = (ch_res != latched_reg);

    // ------------------------------------------------------------------
    // interrupt status, mask and line
    // ------------------------------------------------------------------
    // set beats a clear in the same cycle, so no change is lost
    always_comb begin
        irq_sts_next = irq_sts_reg;
        if (reg_wr_i && (reg_addr_i == DCC_IRQ_STS_ADDR)) begin
            irq_sts_next = irq_sts_next & ~reg_wdata_i[1:0];
        end
        if (mismatch) begin
            irq_sts_next[DCC_IRQ_CHANGE_BIT] = 1'b1;
        end
        if (settle_done) begin
            irq_sts_next[DCC_IRQ_SETTLED_BIT] = 1'b1;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            irq_sts_reg <= DCC_IRQ_RST;
        end else begin
            irq_sts_reg <= irq_sts_next;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            irq_mask_reg <= DCC_IRQ_RST;
        end else if (reg_wr_i && (reg_addr_i == DCC_IRQ_MASK_ADDR)) begin
            irq_mask_reg <= reg_wdata_i[1:0];
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= |(irq_sts_reg & irq_mask_reg);
        end
    end

    // ------------------------------------------------------------------
    // port A direction, data and pads
    // ------------------------------------------------------------------
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            dir_reg <= DCC_DIR_RST;
            data_reg <= DCC_DATA_RST;
        end else begin
            if (reg_wr_i && (reg_addr_i == DCC_PORT_DIR_ADDR)) begin
                dir_reg <= reg_wdata_i[4:0];
            end
            if (reg_wr_i && (reg_addr_i == DCC_PORT_DATA_ADDR)) begin
                data_reg <= reg_wdata_i[4:0];
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pin_meta_reg <= 5'h00;
            pin_sync_reg <= 5'h00;
        end else begin
            pin_meta_reg <= pin_a_in_i;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // direction bit 1 means input; it still gates drive in comparator modes
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            pin_a_out_o <= 5'h00;
            pin_a_oe_o <= 5'h00;
        end else begin
            pin_a_oe_o <= ~dir_reg;
            pin_a_out_o[2:0] <= data_reg[2:0];
            if (dec.outputs_to_pins) begin
                pin_a_out_o[4:3] <= ch_res;
            end else begin
                pin_a_out_o[4:3] <= data_reg[4:3];
            end
        end
    end

    // ------------------------------------------------------------------
    // read data, valid only in the cycle after the strobe
    // ------------------------------------------------------------------
    always_comb begin
        rdata_next = 8'h00;
        case (reg_addr_i)
            DCC_CFG_ADDR: begin
                rdata_next = {ch_res[1], ch_res[0], cfg_reg};
            end
            DCC_IRQ_STS_ADDR: begin
                rdata_next = {6'h00, irq_sts_reg};
            end
            DCC_IRQ_MASK_ADDR: begin
                rdata_next = {6'h00, irq_mask_reg};
            end
            DCC_PORT_DIR_ADDR: begin
                rdata_next = {3'h0, dir_reg};
            end
            DCC_PORT_DATA_ADDR: begin
                // analog pins read low so their input buffers carry no meaning
                rdata_next = {3'h0, pin_sync_reg & ~dec.analog_pins};
            end
            DCC_STATE_ADDR: begin
                rdata_next = {5'h00, latched_reg, settling};
            end
            default: begin
                rdata_next = 8'h00;
            end
        endcase
    end

    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i) begin
            reg_rdata_o <= DCC_RDATA_RST;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rdata_next;
        end else begin
            reg_rdata_o <= DCC_RDATA_RST;
        end
    end

endmodule

`default_nettype wire

// ===== test/dcc_top_asserts.sv
/* Port checker for dcc_top.
   Assumes it is bound into dcc_top and sees only its ports. */
`default_nettype none

module dcc_top_asserts
    import dcc_pkg::*;
(
    // clock and reset
    input wire logic sys_clk_i,
    input wire logic rst_b_i,
    // register port
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    // routing, pins, status
    input var dcc_pkg::dcc_route_t first_route_o,
    input var dcc_pkg::dcc_route_t second_route_o,
    input wire logic [4:0] pin_a_oe_o,
    input wire logic [4:0] pin_a_analog_o,
    input wire logic result_valid_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // saturates, so a long idle stretch cannot wrap
    logic [11:0] low_cnt_reg;
    always_ff @(posedge sys_clk_i) begin
        if (!rst_b_i || result_valid_o) begin
            low_cnt_reg <= 12'h000;
        end else if (low_cnt_reg != 12'hfff) begin
            low_cnt_reg <= low_cnt_reg + 12'h001;
        end
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);

    sequence cfg_wr(logic [3:0] v);
        reg_wr_i && reg_addr_i == DCC_CFG_ADDR && reg_wdata_i[3:0] == v;
    endsequence
    sequence mode_wr(logic [2:0] m);
        reg_wr_i && reg_addr_i == DCC_CFG_ADDR && reg_wdata_i[2:0] == m;
    endsequence

    rdata_idle_a: assert property (!$past(reg_rd_i) |-> reg_rdata_o == 8'h00)
        else $error("stray read data");
    unmapped_zero_a: assert property (reg_rd_i && reg_addr_i == 8'h30 |=> reg_rdata_o == 8'h00)
        else $error("unmapped read not zero");
    common_ref_a: assert property (cfg_wr(4'h3) |-> ##2 pin_a_analog_o == 5'h07
        && first_route_o == {1'b1, DCC_PIN_A0, 1'b0, DCC_PIN_A2}
        && second_route_o == {1'b1, DCC_PIN_A1, 1'b0, DCC_PIN_A2}) else $error("mode 3 routing");
    reset_mode_a: assert property (cfg_wr(4'h0) |-> ##2 pin_a_analog_o == 5'h0f
        && first_route_o == DCC_ROUTE_OFF && second_route_o == DCC_ROUTE_OFF)
        else $error("mode 0 routing");
    vref_route_a: assert property (mode_wr(3'h2) |-> ##2 first_route_o.noninverting_vref
        && second_route_o.noninverting_vref) else $error("reference not routed");
    off_mode_a: assert property (mode_wr(3'h7) |-> ##2 !first_route_o.enable
        && !second_route_o.enable && pin_a_analog_o == 5'h00) else $error("mode 7 not off");
    switch_on_a: assert property (cfg_wr(4'h9) |-> ##2 first_route_o.inverting_pin == DCC_PIN_A3)
        else $error("switch ignored");
    switch_fixed_a: assert property (cfg_wr(4'hc) |-> ##2
        first_route_o == {1'b1, DCC_PIN_A0, 1'b0, DCC_PIN_A3}) else $error("switch leaked");
    property dir_oe_p;
        logic [4:0] d;
        (reg_wr_i && reg_addr_i == DCC_PORT_DIR_ADDR, d = reg_wdata_i[4:0]) |-> ##2 pin_a_oe_o == ~d;
    endproperty
    dir_oe_a: assert property (dir_oe_p)
        else $error("bad output enable");
    settle_time_a: assert property ($rose(result_valid_o) |-> low_cnt_reg >= 12'(DCC_SETTLE_LAST))
        else $error("results valid too early");
endmodule

bind dcc_top dcc_top_asserts dcc_top_asserts_inst (
    .sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o,
    .first_route_o, .second_route_o, .pin_a_oe_o, .pin_a_analog_o, .result_valid_o
);

`default_nettype wire

// ===== test/dcc_analog_model.sv
/* Analog side: two comparators and the reference.
   Assumes 8-bit level codes. */
`default_nettype none

module dcc_analog_model
    import dcc_pkg::*;
(
    // clock
    input wire logic clk_i,
    // routing from the block
    input var dcc_pkg::dcc_route_t first_route_i,
    input var dcc_pkg::dcc_route_t second_route_i,
    // levels a3..a0 and reference
    input wire logic [31:0] pin_lvl_i,
    input wire logic [7:0] vref_lvl_i,
    // decisions
    output logic [1:0] raw_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic toggle_reg = 1'b0;
    always_ff @(posedge clk_i) begin
        toggle_reg <= ~toggle_reg;
    end
    function automatic logic decide(dcc_route_t r, logic [31:0] lv, logic [7:0] vr, logic nz);
        logic [7:0] pos;
        logic [7:0] neg;
        pos = r.noninverting_vref ? vr : lv[8 * r.noninverting_pin +: 8];
        neg = lv[8 * r.inverting_pin +: 8];
        return r.enable ? (pos > neg) : nz;
    endfunction
    // powered-down comparators chatter, so nothing relies on a stale level
    assign raw_o = {decide(second_route_i, pin_lvl_i, vref_lvl_i, toggle_reg),
        decide(first_route_i, pin_lvl_i, vref_lvl_i, ~toggle_reg)};
endmodule

`default_nettype wire

// ===== test/tb.sv
/* Self-checking bench for dcc_top and the analog model.
   Assumes the bound checker; pads read all high. */
`default_nettype none

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import dcc_pkg::*;
    localparam logic [7:0] MODES [8] = '{8'h00, 8'h09, 8'h02, 8'h03, 8'h0c, 8'h05, 8'h06, 8'h07};
    logic sys_clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00;
    logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic [4:0] pin_a_in_i = 5'h1f;
    logic [31:0] pin_lvl = 32'h00325a0a;
    logic [7:0] reg_rdata_o;
    logic [1:0] cmp_raw_i;
    dcc_route_t first_route_o, second_route_o;
    logic [4:0] pin_a_out_o, pin_a_oe_o, pin_a_analog_o;
    logic result_valid_o, irq_o;
    int n_mismatch = 0, compares = 0, cycles = 0;

    always #2 sys_clk_i = ~sys_clk_i;

    dcc_top dcc_top_inst (.sys_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .cmp_raw_i, .first_route_o, .second_route_o, .pin_a_in_i, .pin_a_out_o,
        .pin_a_oe_o, .pin_a_analog_o, .result_valid_o, .irq_o);
    dcc_analog_model dcc_analog_model_inst (.clk_i(sys_clk_i), .first_route_i(first_route_o),
        .second_route_i(second_route_o), .pin_lvl_i(pin_lvl), .vref_lvl_i(8'h3c),
        .raw_o(cmp_raw_i));

    task tally_and_finish;
        $display("mismatches %0d compares %0d", n_mismatch, compares);
        if (n_mismatch == 0 && compares > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge sys_clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    task cmp(input string what, input logic [7:0] exp, got);
        compares++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, d);
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b1;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge sys_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    // data stand one cycle only, so sample just past that edge
    task check_reg(input string what, input logic [7:0] a, exp, mask);
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b1;
        reg_addr_i <= a;
        @(posedge sys_clk_i);
        reg_rd_i <= 1'b0;
        #1 cmp(what, exp, reg_rdata_o & mask);
    endtask
    task settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask

    task t_reset;
        cmp("analog", 8'h0f, {3'h0, pin_a_analog_o});
        cmp("oe", 8'h00, {3'h0, pin_a_oe_o});
        check_reg("config", DCC_CFG_ADDR, 8'h00, 8'hff);
        check_reg("unmapped", 8'h30, 8'h00, 8'hff);
    endtask
    task t_modes;
        wr(DCC_IRQ_MASK_ADDR, 8'h00);
        for (int i = 0; i < 8; i++) begin
            wr(DCC_CFG_ADDR, MODES[i]);
            check_reg("mode", DCC_CFG_ADDR, MODES[i], 8'h3f);
        end
        cmp("off analog", 8'h00, {3'h0, pin_a_analog_o});
    endtask
    task t_compare;
        int n;
        n = 0;
        wr(DCC_CFG_ADDR, 8'hc3);
        while (result_valid_o !== 1'b1 && n < 3000) begin
            settle(1);
            n++;
        end
        cmp("settle long", 8'h01, {7'h00, n >= DCC_SETTLE_CYCLES});
        check_reg("results", DCC_CFG_ADDR, 8'h43, 8'hff);
        check_reg("settle done", DCC_IRQ_STS_ADDR, 8'h02, 8'h02);
        check_reg("port read", DCC_PORT_DATA_ADDR, 8'h18, 8'hff);
    endtask
    task t_invert;
        wr(DCC_CFG_ADDR, 8'hd3);
        settle(6);
        check_reg("inv first", DCC_CFG_ADDR, 8'h13, 8'hff);
        wr(DCC_CFG_ADDR, 8'h23);
        settle(6);
        check_reg("inv second", DCC_CFG_ADDR, 8'he3, 8'hff);
    endtask
    task t_irq;
        wr(DCC_IRQ_STS_ADDR, 8'h03);
        wr(DCC_IRQ_MASK_ADDR, 8'h01);
        settle(3);
        cmp("irq idle", 8'h00, {7'h00, irq_o});
        @(posedge sys_clk_i);
        pin_lvl[7:0] <= 8'h46;
        settle(8);
        cmp("irq set", 8'h01, {7'h00, irq_o});
        wr(DCC_IRQ_STS_ADDR, 8'h01);
        settle(3);
        cmp("irq held", 8'h01, {7'h00, irq_o});
        wr(DCC_IRQ_MASK_ADDR, 8'h00);
        settle(3);
        cmp("irq masked", 8'h00, {7'h00, irq_o});
        check_reg("latched", DCC_CFG_ADDR, 8'ha3, 8'hff);
        wr(DCC_IRQ_STS_ADDR, 8'h01);
        wr(DCC_IRQ_MASK_ADDR, 8'h01);
        settle(3);
        cmp("irq cleared", 8'h00, {7'h00, irq_o});
    endtask
    task t_pins;
        wr(DCC_PORT_DIR_ADDR, 8'h07);
        wr(DCC_PORT_DATA_ADDR, 8'h18);
        settle(3);
        cmp("oe", 8'h18, {3'h0, pin_a_oe_o});
        cmp("out", 8'h18, {3'h0, pin_a_out_o});
    endtask

    initial begin
        repeat (12) @(posedge sys_clk_i);
        rst_b_i <= 1'b1;
        settle(1);
        t_reset();
        t_modes();
        t_compare();
        t_invert();
        t_irq();
        t_pins();
        tally_and_finish();
    end
endmodule

`default_nettype wire
